//--- design/thermal_throttle_pkg.sv
package thermal_throttle_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CUM = 5'h00;
    localparam logic [4:0] OFS_DUTY = 5'h04;
    localparam logic [4:0] OFS_PERIOD = 5'h08;
    localparam logic [4:0] OFS_CTL = 5'h0C;
    localparam logic [4:0] OFS_ASRT = 5'h10;
    localparam logic [4:0] OFS_LIMIT = 5'h14;

    // control/status field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_FILT_BIT = 1;
    localparam int CTL_AFLAG_BIT = 2;
    localparam int CTL_PFLAG_BIT = 3;
    localparam int CTL_AIE_BIT = 4;
    localparam int CTL_PIE_BIT = 5;
    localparam int CTL_FORCE_BIT = 6;

    // reset values
    localparam logic [23:0] PERIOD_RST = 24'h00_0000;
    localparam logic [15:0] LIMIT_RST = 16'hFFFF;
    localparam logic [23:0] CNT24_ZERO = 24'h00_0000;
    localparam logic [15:0] CNT16_ZERO = 16'h0000;
    localparam logic [15:0] CNT16_MAX = 16'hFFFF;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int GLITCH_NS = 31;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] GLITCH_LAST = 2'(GLITCH_CYC - 1);
    localparam int FILT_TICKS = 40;
    localparam logic [15:0] FILT_TICKS16 = 16'(FILT_TICKS);
    localparam logic [23:0] COMMIT_ADD = 24'(FILT_TICKS + 1);

    // control/status register image
    typedef struct packed {
        logic force_sel;
        logic period_ie;
        logic assert_ie;
        logic period_expired_flag;
        logic assertion_limit_flag;
        logic filt_en;
        logic mon_en;
    } ctrl_s;

    localparam ctrl_s CTRL_RST = '0;
endpackage : thermal_throttle_pkg

//--- design/thermal_throttle_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module thermal_throttle_monitor (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic slow_tick_enable,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // throttle pin, open drain
    input wire logic thermal_throttle_n_i,
    output logic thermal_throttle_n_o,
    output logic thermal_throttle_n_oe,
    // pulse unit output, high asks for assertion
    input wire logic force_pulse_unit,
    // aggregator source bit
    output logic monitor_irq_source_bit
);

    // byte-lane merge for writable registers
    function automatic logic [31:0] merge32(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge32

    logic ack_q;
    logic [31:0] readdata_q;
    logic sync1_q, sync2_q, filt_q;
    logic [1:0] gcnt_q;
    thermal_throttle_pkg::ctrl_s ctl_q;
    logic [23:0] period_q, dc_cnt_q, cum_q, duty_q;
    logic [15:0] limit_q, asrt_cnt_q, asrt_reg_q, hold_q;
    logic irq_q, force_q;

    // bus handshake: one wait cycle then answer
    wire req = read | write;
    wire req_go = req & ~ack_q & clk_en;
    wire take = req & ack_q & clk_en;
    wire wr_take = write & take;
    assign waitrequest = req & ~(ack_q & clk_en);
    assign readdata = readdata_q;

    // address decode
    wire sel_cum = (address == thermal_throttle_pkg::OFS_CUM);
    wire sel_duty = (address == thermal_throttle_pkg::OFS_DUTY);
    wire sel_period = (address == thermal_throttle_pkg::OFS_PERIOD);
    wire sel_ctl = (address == thermal_throttle_pkg::OFS_CTL);
    wire sel_asrt = (address == thermal_throttle_pkg::OFS_ASRT);
    wire sel_limit = (address == thermal_throttle_pkg::OFS_LIMIT);

    // write data merged into each writable register
    wire [31:0] period_m = merge32({8'h00, period_q}, writedata, byteenable);
    wire [31:0] limit_m = merge32({16'h0000, limit_q}, writedata, byteenable);
    wire [31:0] ctl_m = merge32({25'h000_0000, ctl_q}, writedata, byteenable);
    wire ctl_wr = wr_take & sel_ctl;
    wire clr_aflag = ctl_wr & byteenable[0] & writedata[thermal_throttle_pkg::CTL_AFLAG_BIT];
    wire clr_pflag = ctl_wr & byteenable[0] & writedata[thermal_throttle_pkg::CTL_PFLAG_BIT];

    // counting qualifiers
    wire mon_en = ctl_q.mon_en;
    wire low = ~filt_q;
    wire tk = clk_en & slow_tick_enable & mon_en;
    wire low_tk = tk & low;
    wire asrt_inc = low_tk & (asrt_cnt_q != thermal_throttle_pkg::CNT16_MAX);
    wire [15:0] asrt_nxt = asrt_cnt_q + 16'h0001;
    wire hit = asrt_inc & (asrt_nxt >= limit_q);
    wire cum_valid = asrt_cnt_q > thermal_throttle_pkg::FILT_TICKS16;
    wire commit = low_tk & (asrt_cnt_q == thermal_throttle_pkg::FILT_TICKS16);
    wire cum_step = low_tk & cum_valid;
    wire [23:0] dc_nxt = dc_cnt_q + 24'h00_0001;
    wire expire = tk & (period_q != thermal_throttle_pkg::CNT24_ZERO) & (dc_nxt >= period_q);

    // readback: narrow non-byte0 cumulative reads see held bytes
    wire cum_full = (byteenable == 4'hF) | byteenable[0];
    wire [31:0] cum_word = cum_full ? {8'h00, cum_q} : {8'h00, hold_q, cum_q[7:0]};
    wire [31:0] rd_word = sel_cum ? cum_word :
                          sel_duty ? {8'h00, duty_q} :
                          sel_period ? {8'h00, period_q} :
                          sel_ctl ? {25'h000_0000, ctl_q} :
                          sel_asrt ? {16'h0000, asrt_reg_q} :
                          sel_limit ? {16'h0000, limit_q} : 32'h0000_0000;

    // bus state and read data
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
            hold_q <= thermal_throttle_pkg::CNT16_ZERO;
        end else if (clk_en) begin
            ack_q <= req_go;
            if (req_go & read) begin
                readdata_q <= rd_word;
            end
            if (req_go & read & sel_cum & byteenable[0]) begin
                hold_q <= cum_q[23:8];
            end
        end
    end

    // two-flop sync of the pin, sampled on every cycle with clk_en high
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (clk_en) begin
            sync1_q <= thermal_throttle_n_i;
            sync2_q <= sync1_q;
        end
    end

    // glitch filter: new level must persist GLITCH_CYC samples
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            filt_q <= 1'b1;
            gcnt_q <= 2'h0;
        end else if (clk_en) begin
            if (!ctl_q.filt_en || sync2_q == filt_q) begin
                filt_q <= sync2_q;
                gcnt_q <= 2'h0;
            end else if (gcnt_q == thermal_throttle_pkg::GLITCH_LAST) begin
                filt_q <= sync2_q;
                gcnt_q <= 2'h0;
            end else begin
                gcnt_q <= gcnt_q + 2'h1;
            end
        end
    end

    // writable configuration and status flags
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            ctl_q <= thermal_throttle_pkg::CTRL_RST;
            period_q <= thermal_throttle_pkg::PERIOD_RST;
            limit_q <= thermal_throttle_pkg::LIMIT_RST;
        end else if (clk_en) begin
            if (ctl_wr) begin
                ctl_q.mon_en <= ctl_m[thermal_throttle_pkg::CTL_EN_BIT];
                ctl_q.filt_en <= ctl_m[thermal_throttle_pkg::CTL_FILT_BIT];
                ctl_q.assert_ie <= ctl_m[thermal_throttle_pkg::CTL_AIE_BIT];
                ctl_q.period_ie <= ctl_m[thermal_throttle_pkg::CTL_PIE_BIT];
                ctl_q.force_sel <= ctl_m[thermal_throttle_pkg::CTL_FORCE_BIT];
            end
            // set wins over write-one-to-clear
            ctl_q.assertion_limit_flag <= hit | (ctl_q.assertion_limit_flag & ~clr_aflag);
            ctl_q.period_expired_flag <= expire | (ctl_q.period_expired_flag & ~clr_pflag);
            if (wr_take & sel_period) begin
                period_q <= period_m[23:0];
            end
            if (wr_take & sel_limit) begin
                limit_q <= limit_m[15:0];
            end
        end
    end

    // single-assertion timer and its snapshot
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            asrt_cnt_q <= thermal_throttle_pkg::CNT16_ZERO;
            asrt_reg_q <= thermal_throttle_pkg::CNT16_ZERO;
        end else if (clk_en) begin
            if (!mon_en || !low) begin
                asrt_cnt_q <= thermal_throttle_pkg::CNT16_ZERO;
            end else if (asrt_inc) begin
                asrt_cnt_q <= asrt_nxt;
            end
            if (hit) begin
                asrt_reg_q <= asrt_nxt;
            end
        end
    end

    // cumulative, period and duty counters
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cum_q <= thermal_throttle_pkg::CNT24_ZERO;
            dc_cnt_q <= thermal_throttle_pkg::CNT24_ZERO;
            duty_q <= thermal_throttle_pkg::CNT24_ZERO;
        end else if (clk_en) begin
            if (!mon_en || expire) begin
                cum_q <= thermal_throttle_pkg::CNT24_ZERO;
                dc_cnt_q <= thermal_throttle_pkg::CNT24_ZERO;
            end else begin
                if (commit) begin
                    cum_q <= cum_q + thermal_throttle_pkg::COMMIT_ADD;
                end else if (cum_step) begin
                    cum_q <= cum_q + 24'h00_0001;
                end
                if (tk) begin
                    dc_cnt_q <= dc_nxt;
                end
            end
            if (expire) begin
                duty_q <= cum_q;
            end
        end
    end

    // interrupt and force output
    wire irq_d = (ctl_q.assertion_limit_flag & ctl_q.assert_ie) |
                 (ctl_q.period_expired_flag & ctl_q.period_ie);
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            irq_q <= 1'b0;
            force_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= irq_d;
            force_q <= ctl_q.force_sel & force_pulse_unit;
        end
    end
    assign monitor_irq_source_bit = irq_q;
    assign thermal_throttle_n_o = 1'b0;
    assign thermal_throttle_n_oe = force_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    chk_disabled_idle: assert property (
        clk_en && !mon_en |=> cum_q == 24'h00_0000 && asrt_cnt_q == 16'h0000)
        else $error("counters not idle while disabled");
    chk_irq_follows: assert property (
        clk_en && irq_d |=> monitor_irq_source_bit)
        else $error("irq missing while flag enabled");
    chk_irq_gated: assert property (
        clk_en && !irq_d |=> !monitor_irq_source_bit)
        else $error("irq without enabled flag");
    chk_asrt_clear_high: assert property (
        clk_en && filt_q |=> asrt_cnt_q == 16'h0000)
        else $error("assertion counter not cleared");
    chk_limit_flag: assert property (
        hit |=> ctl_q.assertion_limit_flag && asrt_reg_q == $past(asrt_cnt_q) + 16'h0001)
        else $error("limit hit not recorded");
    chk_cum_holds_high: assert property (
        clk_en && mon_en && filt_q && !expire |=> $stable(cum_q))
        else $error("cumulative moved while high");
    chk_period_clear: assert property (
        expire |=> cum_q == 24'h00_0000 && duty_q == $past(cum_q))
        else $error("expiry did not copy and clear");
    chk_short_pulse: assert property (
        clk_en && mon_en && !expire && asrt_cnt_q < thermal_throttle_pkg::FILT_TICKS16
        |=> $stable(cum_q))
        else $error("short pulse counted");
    chk_commit_step: assert property (
        commit && !expire |=> cum_q == $past(cum_q) + 24'h00_0029)
        else $error("commit added wrong amount");
    chk_hold_capture: assert property (
        req_go && read && sel_cum && byteenable[0] |=> hold_q == $past(cum_q[23:8]))
        else $error("upper bytes not held");
    chk_glitch_hold: assert property (
        clk_en && ctl_q.filt_en && sync2_q != filt_q &&
        gcnt_q != thermal_throttle_pkg::GLITCH_LAST |=> $stable(filt_q))
        else $error("short glitch passed the filter");
    chk_asrt_step: assert property (
        asrt_inc |=> asrt_cnt_q == $past(asrt_cnt_q) + 16'h0001)
        else $error("assertion counter did not step");
    chk_force_gated: assert property (
        clk_en && !ctl_q.force_sel |=> !thermal_throttle_n_oe)
        else $error("pin pulled without force select");
    chk_sync_two_stage: assert property (
        clk_en |=> sync2_q == $past(sync1_q))
        else $error("pin not passed through both stages");

    cov_limit_hit: cover property (hit);
    cov_period_expire: cover property (expire);
    cov_commit: cover property (commit ##[1:20] cum_step);
    cov_glitch_blocked: cover property (ctl_q.filt_en && sync2_q != filt_q ##1 sync2_q == filt_q);
    cov_force_active: cover property (thermal_throttle_n_oe && low_tk);

endmodule : thermal_throttle_monitor
`default_nettype wire

//--- verification/throttle_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module throttle_host_model (
    // clock and tick
    input wire logic ref_clk,
    input wire logic slow_tick_enable,
    // command from bench
    input wire logic go,
    input wire logic [7:0] low_ticks,
    // pin pull-down and status
    output var logic drive_low = 1'b0,
    output logic busy
);
    logic pend_q = 1'b0;
    logic [7:0] left_q = 8'h00;
    // drop the pin at a tick and release it after the commanded tick count
    always_ff @(posedge ref_clk) begin
        if (go) begin
            pend_q <= 1'b1;
        end
        if (slow_tick_enable && pend_q) begin
            pend_q <= 1'b0;
            drive_low <= 1'b1;
            left_q <= low_ticks;
        end else if (slow_tick_enable && drive_low) begin
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
                drive_low <= 1'b0;
            end
        end
    end
    assign busy = pend_q | drive_low;
endmodule : throttle_host_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic slow_tick_enable = 1'b0;
    logic [2:0] tick_q = 3'h0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hf;
    logic force_pulse_unit = 1'b0;
    logic go = 1'b0;
    logic [7:0] low_ticks = 8'h00;
    logic clk_en = 1'b1;
    logic glitch = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, pin_n, pin_o, pin_oe, irq, drive_low, busy;
    logic [31:0] rd, exp, held, seed;
    logic [7:0] len;
    int fail_count = 0;
    int n_tests = 0;
    int n;

    // clock, tick every 8 cycles, open-drain pin with pull-up
    always #12.5 ref_clk = !ref_clk;
    always @(posedge ref_clk) begin
        tick_q <= tick_q + 3'h1;
        slow_tick_enable <= (tick_q == 3'h7);
    end
    assign pin_n = !(drive_low || glitch || (pin_oe && !pin_o));

    thermal_throttle_monitor thermal_throttle_monitor_i (.ref_clk(ref_clk), .resetn(resetn),
        .clk_en(clk_en), .slow_tick_enable(slow_tick_enable), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .thermal_throttle_n_i(pin_n), .thermal_throttle_n_o(pin_o),
        .thermal_throttle_n_oe(pin_oe), .force_pulse_unit(force_pulse_unit),
        .monitor_irq_source_bit(irq));
    throttle_host_model throttle_host_model_i (.ref_clk(ref_clk),
        .slow_tick_enable(slow_tick_enable), .go(go), .low_ticks(low_ticks),
        .drive_low(drive_low), .busy(busy));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= w;
        read <= !w;
        // request stands until the edge that samples waitrequest low
        do begin
            @(posedge ref_clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t got %h want %h", $time, g, e);
        end
    endtask : chk

    // one host assertion of len ticks, then let the synchroniser settle
    task automatic pulse(input logic [7:0] l);
        int k;
        k = 0;
        low_ticks <= l;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        do begin
            @(posedge ref_clk);
            k++;
        end while ((busy !== 1'b0 || k < 2) && k < 3000);
        if (k >= 3000) begin
            fail_count++;
            $display("FAIL t=%0t host pulse did not end", $time);
        end
        repeat (6) @(posedge ref_clk);
    endtask : pulse

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #1000000;
        fail_count++;
        $display("FAIL t=%0t watchdog expired", $time);
        tally_and_finish;
    end

    // main sequence
    initial begin
        seed = 32'h0000_d30d;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(1'b0, thermal_throttle_pkg::OFS_CTL, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        bus(1'b0, thermal_throttle_pkg::OFS_LIMIT, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_ffff);
        pulse(8'h32);
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        bus(1'b1, thermal_throttle_pkg::OFS_LIMIT, 32'h0000_0014, 4'hf, rd);
        bus(1'b1, thermal_throttle_pkg::OFS_CTL, 32'h0000_0011, 4'hf, rd);
        pulse(8'h1e);
        bus(1'b0, thermal_throttle_pkg::OFS_CTL, 32'h0000_0000, 4'hf, rd);
        chk({31'h0000_0000, rd[2]}, 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b0, thermal_throttle_pkg::OFS_ASRT, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_001e);
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        bus(1'b1, thermal_throttle_pkg::OFS_CTL, 32'h0000_0005, 4'hf, rd);
        repeat (3) @(posedge ref_clk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        pulse(8'h19);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        // corner lengths then random ones, filter on or off at random
        exp = 32'h0000_0000;
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            len = (i == 0) ? 8'h28 : (i == 1) ? 8'h29 : 8'h14 + 8'(seed[5:0] % 41);
            bus(1'b1, thermal_throttle_pkg::OFS_CTL, {30'h0000_0000, seed[9], 1'b1}, 4'hf, rd);
            pulse(len);
            if (len > 8'h28) exp = exp + 32'(len);
        end
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, exp);
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'h1, rd);
        held = exp;
        pulse(8'h2d);
        exp = exp + 32'h0000_002d;
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'h6, rd);
        chk({16'h0000, rd[23:8]}, {16'h0000, held[23:8]});
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, exp);
        // forced assertion of 45 ticks through the pulse unit
        bus(1'b1, thermal_throttle_pkg::OFS_CTL, 32'h0000_0041, 4'hf, rd);
        do @(posedge ref_clk); while (slow_tick_enable !== 1'b1);
        force_pulse_unit <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk({31'h0000_0000, pin_oe}, 32'h0000_0001);
        repeat (352) @(posedge ref_clk);
        force_pulse_unit <= 1'b0;
        repeat (8) @(posedge ref_clk);
        exp = exp + 32'h0000_002d;
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, exp);
        // period expiry
        bus(1'b1, thermal_throttle_pkg::OFS_PERIOD, 32'h0000_0014, 4'hf, rd);
        bus(1'b1, thermal_throttle_pkg::OFS_CTL, 32'h0000_0021, 4'hf, rd);
        n = 0;
        do begin
            bus(1'b0, thermal_throttle_pkg::OFS_CTL, 32'h0000_0000, 4'hf, rd);
            n++;
        end while (rd[3] !== 1'b1 && n < 200);
        chk({31'h0000_0000, rd[3]}, 32'h0000_0001);
        bus(1'b0, thermal_throttle_pkg::OFS_DUTY, 32'h0000_0000, 4'hf, rd);
        chk(rd, exp);
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        // period off, expiry flag cleared, then a 42-tick pulse counts in full
        bus(1'b1, thermal_throttle_pkg::OFS_PERIOD, 32'h0000_0000, 4'hf, rd);
        bus(1'b1, thermal_throttle_pkg::OFS_CTL, 32'h0000_0009, 4'hf, rd);
        pulse(8'h2a);
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_002a);
        // clock enable low stalls the bus answer and holds the total
        fork
            begin
                repeat (2) @(posedge ref_clk);
                clk_en <= 1'b0;
                repeat (6) @(posedge ref_clk);
                chk({31'h0000_0000, waitrequest}, 32'h0000_0001);
                clk_en <= 1'b1;
            end
            bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        join
        chk(rd, 32'h0000_002a);
        bus(1'b1, thermal_throttle_pkg::OFS_CTL, 32'h0000_0000, 4'hf, rd);
        bus(1'b0, thermal_throttle_pkg::OFS_CUM, 32'h0000_0000, 4'hf, rd);
        chk(rd, 32'h0000_0000);
        // one-cycle lows every third cycle: dropped with the filter, counted without
        bus(1'b1, thermal_throttle_pkg::OFS_LIMIT, 32'h0000_0001, 4'hf, rd);
        for (int f = 1; f >= 0; f--) begin
            bus(1'b1, thermal_throttle_pkg::OFS_CTL, {29'h0000_0000, 1'b1, f[0], 1'b1}, 4'hf, rd);
            repeat (8) begin
                glitch <= 1'b1;
                @(posedge ref_clk);
                glitch <= 1'b0;
                repeat (2) @(posedge ref_clk);
            end
            repeat (4) @(posedge ref_clk);
            bus(1'b0, thermal_throttle_pkg::OFS_CTL, 32'h0000_0000, 4'hf, rd);
            chk({31'h0000_0000, rd[2]}, {31'h0000_0000, !f[0]});
        end
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
